//--- logic/cscr_defs.svh
// Constants for the core status and timer/prescaler configuration registers.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CSCR_DEFS_SVH
`define CSCR_DEFS_SVH

// File address of the status register
`define CSCR_STATUS_ADDR 5'h03

// Status bit positions
`define CSCR_BIT_WAKE 7
`define CSCR_BIT_UNUSED 6
`define CSCR_BIT_PAGE 5
`define CSCR_BIT_TIMEOUT 4
`define CSCR_BIT_PWR_DOWN 3
`define CSCR_BIT_Z 2
`define CSCR_BIT_DIG_CARRY 1
`define CSCR_BIT_C 0

// Reset values
`define CSCR_STATUS_POR 8'h18
`define CSCR_OPTION_RST 8'hFF

// Configuration bit positions
`define CSCR_OPT_WAKE_DIS 7
`define CSCR_OPT_PULL_DIS 6
`define CSCR_OPT_CLK_SRC 5

// Pin set: six general pins, pull-up and wake only on pins 0, 1 and 3
`define CSCR_NUM_PINS 6
`define CSCR_PIN_PULL_MASK 6'h0B
`define CSCR_PIN_FORCE_IN 2

`endif

//--- logic/cscr_pkg.sv
// Types shared by the status/configuration register block and its flag unit.
// Assumes the constants header sits beside it.
`include "cscr_defs.svh"

package cscr_pkg;

  // Operation of the instruction executed this cycle
  typedef enum logic [3:0] {
    CSCR_OP_MOVE,
    CSCR_OP_CLR,
    CSCR_OP_ADD,
    CSCR_OP_SUB,
    CSCR_OP_AND,
    CSCR_OP_IOR,
    CSCR_OP_XOR,
    CSCR_OP_BCLR,
    CSCR_OP_BSET,
    CSCR_OP_RLF,
    CSCR_OP_RRF
  } cscr_alu_op_t;

  // Cause of the reset presented with the reset strobe
  typedef enum logic [1:0] {
    CSCR_RST_POWER,
    CSCR_RST_CLEAR,
    CSCR_RST_WATCHDOG,
    CSCR_RST_PIN_WAKE
  } cscr_rst_kind_t;

endpackage : cscr_pkg

//--- logic/cscr_flag_unit.sv
// Result and arithmetic flag computation for one instruction.
// Assumes the core presents both operands and the carry in the same cycle.
`timescale 1ns/10ps

module cscr_flag_unit
  import cscr_pkg::*;
(
  input wire cscr_alu_op_t op_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] file_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic carry_i,
  output logic [7:0] result_o,
  output logic z_o,
  output logic dig_carry_o,
  output logic c_o,
  output logic upd_z_o,
  output logic upd_dig_carry_o,
  output logic upd_c_o
);

  logic [8:0] sum;
  logic [4:0] nib;

  // Result and flags; moves and bit operations touch no flag
  always_comb
  begin
    sum = 9'h000;
    nib = 5'h00;
    result_o = file_i;
    dig_carry_o = 1'b0;
    c_o = 1'b0;
    upd_z_o = 1'b0;
    upd_dig_carry_o = 1'b0;
    upd_c_o = 1'b0;
    case (op_i)
      CSCR_OP_ADD:
      begin
        sum = {1'b0, file_i} + {1'b0, acc_i};
        nib = {1'b0, file_i[3:0]} + {1'b0, acc_i[3:0]};
        result_o = sum[7:0];
        c_o = sum[8];
        dig_carry_o = nib[4];
        upd_z_o = 1'b1;
        upd_dig_carry_o = 1'b1;
        upd_c_o = 1'b1;
      end
      CSCR_OP_SUB:
      begin
        sum = {1'b0, file_i} + {1'b0, ~acc_i} + 9'h001;
        nib = {1'b0, file_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
        result_o = sum[7:0];
        c_o = sum[8];
        dig_carry_o = nib[4];
        upd_z_o = 1'b1;
        upd_dig_carry_o = 1'b1;
        upd_c_o = 1'b1;
      end
      CSCR_OP_AND:
      begin
        result_o = file_i & acc_i;
        upd_z_o = 1'b1;
      end
      CSCR_OP_IOR:
      begin
        result_o = file_i | acc_i;
        upd_z_o = 1'b1;
      end
      CSCR_OP_XOR:
      begin
        result_o = file_i ^ acc_i;
        upd_z_o = 1'b1;
      end
      CSCR_OP_CLR:
      begin
        result_o = 8'h00;
        upd_z_o = 1'b1;
      end
      CSCR_OP_MOVE: result_o = acc_i;
      CSCR_OP_BCLR: result_o = file_i & ~(8'h01 << bit_sel_i);
      CSCR_OP_BSET: result_o = file_i | (8'h01 << bit_sel_i);
      CSCR_OP_RLF:
      begin
        result_o = {file_i[6:0], carry_i};
        c_o = file_i[7];
        upd_c_o = 1'b1;
      end
      CSCR_OP_RRF:
      begin
        result_o = {carry_i, file_i[7:1]};
        c_o = file_i[0];
        upd_c_o = 1'b1;
      end
      default: result_o = file_i;
    endcase
    z_o = (result_o == 8'h00);
  end

endmodule : cscr_flag_unit

//--- logic/cscr_regs.sv
// Core status register and write-only timer/prescaler configuration register.
// Assumes the core drives one instruction per clock with synchronous strobes.
//
// Overview of operation
// - Clearing the status register zeroes bits 7..5, sets zero, keeps the rest.
// - Bit clear, bit set and move store the written value in bits 7, 5 and 2..0.
// - Status bit 5 selects program page 1 when set, page 0 when clear.
// - Timeout flag set by power-up, watchdog clear, sleep; cleared by timeout.
// - Digit carry is carry out of bit 3 on add, inverted borrow on subtract.
// - Configuration register is eight bits, write-only, never read back.
// - Only the configuration-load instruction copies the accumulator into it.
// - Any reset sets all eight configuration bits to one.
// - Output pins lose pull-up and wake-on-change regardless of global enables.
// - Timer clock source select set forces general pin two to input.
// - Flag-updating instructions writing status keep computed flags, not data.
// - Timeout and power-down flags ignore instruction writes.
`timescale 1ns/10ps
`include "cscr_defs.svh"

module cscr_regs
  import cscr_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire cscr_rst_kind_t RST_KIND_I,
  input wire logic EXEC_I,
  input wire cscr_alu_op_t ALU_OP_I,
  input wire logic [7:0] ACC_I,
  input wire logic [7:0] FILE_I,
  input wire logic [4:0] FILE_ADDR_I,
  input wire logic [2:0] BIT_SEL_I,
  input wire logic DEST_F_I,
  input wire logic WD_CLEAR_I,
  input wire logic SLEEP_I,
  input wire logic OPT_LOAD_I,
  input wire logic [5:0] PIN_DIR_I,
  output logic [7:0] STATUS_O,
  output logic PAGE_SEL_O,
  output logic [7:0] OPTION_O,
  output logic [5:0] PIN_OUT_EN_O,
  output logic [5:0] PULLUP_EN_O,
  output logic [5:0] WAKE_EN_O
);

  logic [7:0] status;
  logic [7:0] next_status;
  logic [7:0] option;
  logic [7:0] next_option;
  logic [5:0] pin_oe;
  logic [5:0] next_pin_oe;
  logic [5:0] pull_en;
  logic [5:0] next_pull_en;
  logic [5:0] wake_en;
  logic [5:0] next_wake_en;
  logic [7:0] result;
  logic z;
  logic dig_carry;
  logic c;
  logic upd_z;
  logic upd_dig_carry;
  logic upd_c;
  logic any_upd;
  logic wr_status;

  // Pins that have a pull-up and wake-on-change at all
  localparam logic [5:0] pull_mask = `CSCR_PIN_PULL_MASK;

  // Decode of the status register file address
  function automatic logic cscr_is_status(input logic [4:0] addr);
    cscr_is_status = (addr == `CSCR_STATUS_ADDR);
  endfunction : cscr_is_status

  // Result and flags of the current instruction
  cscr_flag_unit u_flag_unit (
    .op_i(ALU_OP_I),
    .acc_i(ACC_I),
    .file_i(FILE_I),
    .bit_sel_i(BIT_SEL_I),
    .carry_i(status[`CSCR_BIT_C]),
    .result_o(result),
    .z_o(z),
    .dig_carry_o(dig_carry),
    .c_o(c),
    .upd_z_o(upd_z),
    .upd_dig_carry_o(upd_dig_carry),
    .upd_c_o(upd_c)
  );

  assign wr_status = EXEC_I && DEST_F_I && cscr_is_status(FILE_ADDR_I);
  assign any_upd = upd_z || upd_dig_carry || upd_c;

  // Next status: reset cause, instruction write, flag update, then events
  always_comb
  begin
    next_status = status;
    if (SRST_I)
    begin
      case (RST_KIND_I)
        CSCR_RST_CLEAR: next_status[7:5] = 3'h0;
        CSCR_RST_WATCHDOG:
        begin
          next_status[7:5] = 3'h0;
          next_status[`CSCR_BIT_TIMEOUT] = 1'b0;
        end
        CSCR_RST_PIN_WAKE: next_status[7:5] = 3'h4;
        default: next_status = `CSCR_STATUS_POR;
      endcase
    end
    else
    begin
      if (wr_status)
      begin
        // Timeout and power-down are not on the write path
        next_status[`CSCR_BIT_WAKE] = result[`CSCR_BIT_WAKE];
        next_status[`CSCR_BIT_UNUSED] = 1'b0;
        next_status[`CSCR_BIT_PAGE] = result[`CSCR_BIT_PAGE];
        if (!any_upd)
        begin
          next_status[2:0] = result[2:0];
        end
      end
      if (EXEC_I && upd_z)
      begin
        next_status[`CSCR_BIT_Z] = z;
      end
      if (EXEC_I && upd_dig_carry)
      begin
        next_status[`CSCR_BIT_DIG_CARRY] = dig_carry;
      end
      if (EXEC_I && upd_c)
      begin
        next_status[`CSCR_BIT_C] = c;
      end
      if (WD_CLEAR_I)
      begin
        next_status[`CSCR_BIT_TIMEOUT] = 1'b1;
        next_status[`CSCR_BIT_PWR_DOWN] = 1'b1;
      end
      if (SLEEP_I)
      begin
        next_status[`CSCR_BIT_TIMEOUT] = 1'b1;
        next_status[`CSCR_BIT_PWR_DOWN] = 1'b0;
      end
    end
  end

  // Next configuration: reset to ones, load from the accumulator only
  always_comb
  begin
    next_option = option;
    if (SRST_I)
    begin
      next_option = `CSCR_OPTION_RST;
    end
    else if (OPT_LOAD_I)
    begin
      next_option = ACC_I;
    end
  end

  // Per-pin direction, pull-up and wake qualification
  genvar g;
  generate
    for (g = 0; g < `CSCR_NUM_PINS; g = g + 1)
    begin : g_pin
      assign next_pin_oe[g] = !SRST_I && !PIN_DIR_I[g] &&
        !((g == `CSCR_PIN_FORCE_IN) && option[`CSCR_OPT_CLK_SRC]);
      assign next_pull_en[g] = !SRST_I && pull_mask[g] && PIN_DIR_I[g] &&
        !option[`CSCR_OPT_PULL_DIS];
      assign next_wake_en[g] = !SRST_I && pull_mask[g] && PIN_DIR_I[g] &&
        !option[`CSCR_OPT_WAKE_DIS];
    end
  endgenerate

  // State registers
  always_ff @(posedge CLK_SYS_I)
  begin
    status <= next_status;
    option <= next_option;
    pin_oe <= next_pin_oe;
    pull_en <= next_pull_en;
    wake_en <= next_wake_en;
  end

  // Outputs straight from the registers
  assign STATUS_O = status;
  assign PAGE_SEL_O = status[`CSCR_BIT_PAGE];
  assign OPTION_O = option;
  assign PIN_OUT_EN_O = pin_oe;
  assign PULLUP_EN_O = pull_en;
  assign WAKE_EN_O = wake_en;

  // Checks on the register behaviour
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);

  logic quiet;
  assign quiet = !WD_CLEAR_I && !SLEEP_I;

  a_clear_status: assert property (
    (wr_status && ALU_OP_I == CSCR_OP_CLR && quiet) |=>
      (STATUS_O[7:5] == 3'h0 && STATUS_O[2] &&
       STATUS_O[4:3] == $past(STATUS_O[4:3]) && STATUS_O[1:0] == $past(STATUS_O[1:0])))
    else $error("Clear of status gave a wrong value");

  a_move_exact: assert property (
    (wr_status && ALU_OP_I == CSCR_OP_MOVE) |=>
      (STATUS_O[5] == $past(ACC_I[5]) && STATUS_O[2:0] == $past(ACC_I[2:0])))
    else $error("Move to status not stored exactly");

  a_page_select: assert property (
    (wr_status && ALU_OP_I == CSCR_OP_BSET && BIT_SEL_I == 3'h5) |=> PAGE_SEL_O)
    else $error("Page select not set by bit set of status bit");

  a_sleep_flags: assert property (
    (SLEEP_I && !WD_CLEAR_I) |=> (STATUS_O[4] && !STATUS_O[3]))
    else $error("Sleep did not set timeout and clear power-down");

  a_digit_carry: assert property (
    (EXEC_I && !wr_status && ALU_OP_I == CSCR_OP_ADD) |=>
      (STATUS_O[1] == ($past(FILE_I[3:0]) + $past(ACC_I[3:0]) > 5'h0F)))
    else $error("Digit carry wrong after add");

  a_option_hold: assert property (
    !OPT_LOAD_I |=> $stable(OPTION_O))
    else $error("Configuration changed without load");

  a_option_load: assert property (
    OPT_LOAD_I |=> OPTION_O == $past(ACC_I))
    else $error("Configuration load lost the accumulator");

  a_option_reset: assert property (disable iff (1'b0)
    SRST_I |=> OPTION_O == 8'hFF)
    else $error("Reset did not set configuration to ones");

  a_output_no_pull: assert property (
    1'b1 |=> ((PULLUP_EN_O | WAKE_EN_O) & ~$past(PIN_DIR_I)) == 6'h00)
    else $error("Output pin kept pull-up or wake");

  a_pin_two_input: assert property (
    OPTION_O[5] |=> !PIN_OUT_EN_O[2])
    else $error("Pin two driven while timer source selected");

  a_flag_guard: assert property (
    (wr_status && ALU_OP_I == CSCR_OP_ADD) |=>
      (STATUS_O[0] == $past(c) && STATUS_O[2] == $past(z)))
    else $error("Status data overwrote computed flags");

  a_to_pd_readonly: assert property (
    (quiet && !SRST_I) |=> $stable(STATUS_O[4:3]))
    else $error("Timeout or power-down changed by a write");

  a_wake_flag: assert property (disable iff (1'b0)
    (SRST_I && RST_KIND_I == CSCR_RST_PIN_WAKE) |=> STATUS_O[7])
    else $error("Pin wake reset did not set wake flag");

  a_zero_flag: assert property (
    (EXEC_I && upd_z && !wr_status) |=> STATUS_O[2] == ($past(result) == 8'h00))
    else $error("Zero flag disagrees with result");

  c_clear_status: cover property (wr_status && ALU_OP_I == CSCR_OP_CLR);
  c_option_load: cover property (OPT_LOAD_I ##1 OPTION_O[5]);
  c_sub_to_status: cover property (wr_status && ALU_OP_I == CSCR_OP_SUB);
  c_sleep_then_wake: cover property (disable iff (1'b0) SLEEP_I ##[1:20] SRST_I);

endmodule : cscr_regs

//--- tb/cscr_regs_tb_top.sv
// Self-checking bench for the status and configuration register block.
// Assumes the package is compiled first; the bench plays the core itself.
`timescale 1ns/10ps

module cscr_regs_tb_top;
  import cscr_pkg::*;

  logic clk;
  logic srst;
  cscr_rst_kind_t kind;
  logic exec;
  cscr_alu_op_t op;
  logic [7:0] acc;
  logic [7:0] file_v;
  logic [4:0] addr;
  logic [2:0] bsel;
  logic dest;
  logic wd_clear;
  logic sleep_p;
  logic opt_load;
  logic [5:0] pin_dir;
  logic [7:0] status;
  logic page;
  logic [7:0] option;
  logic [5:0] out_en;
  logic [5:0] pull_en;
  logic [5:0] wake_en;
  logic [7:0] st;
  logic [7:0] opt;
  logic [7:0] ra;
  logic rd;
  int n_fail;
  int n_compared;
  cscr_alu_op_t ops [11] = '{CSCR_OP_MOVE, CSCR_OP_CLR, CSCR_OP_ADD, CSCR_OP_SUB,
    CSCR_OP_BCLR, CSCR_OP_BSET, CSCR_OP_AND, CSCR_OP_IOR, CSCR_OP_XOR, CSCR_OP_RLF,
    CSCR_OP_RRF};

  cscr_regs dut (.CLK_SYS_I(clk), .SRST_I(srst), .RST_KIND_I(kind), .EXEC_I(exec),
    .ALU_OP_I(op), .ACC_I(acc), .FILE_I(file_v), .FILE_ADDR_I(addr), .BIT_SEL_I(bsel),
    .DEST_F_I(dest), .WD_CLEAR_I(wd_clear), .SLEEP_I(sleep_p), .OPT_LOAD_I(opt_load),
    .PIN_DIR_I(pin_dir), .STATUS_O(status), .PAGE_SEL_O(page), .OPTION_O(option),
    .PIN_OUT_EN_O(out_en), .PULLUP_EN_O(pull_en), .WAKE_EN_O(wake_en));

  // Clock at 250 MHz
  always #2 clk = ~clk;

  // Expected status after one instruction
  function automatic logic [7:0] nxt(cscr_alu_op_t o, logic [7:0] a, logic [7:0] f,
    logic [2:0] b, logic d);
    logic [8:0] r;
    logic [4:0] h;
    logic [7:0] s;
    logic upd;
    s = st;
    upd = 1'b1;
    r = {1'b0, f};
    h = 5'h00;
    case (o)
      CSCR_OP_MOVE:
      begin
        r = {1'b0, a};
        upd = 1'b0;
      end
      CSCR_OP_CLR: r = 9'h000;
      CSCR_OP_ADD:
      begin
        r = {1'b0, a} + {1'b0, f};
        h = {1'b0, a[3:0]} + {1'b0, f[3:0]};
      end
      CSCR_OP_SUB:
      begin
        r = {1'b0, f} - {1'b0, a};
        h = {1'b0, f[3:0]} - {1'b0, a[3:0]};
      end
      CSCR_OP_BSET:
      begin
        r[b] = 1'b1;
        upd = 1'b0;
      end
      CSCR_OP_AND: r = {1'b0, a & f};
      CSCR_OP_IOR: r = {1'b0, a | f};
      CSCR_OP_XOR: r = {1'b0, a ^ f};
      // Rotates through carry: bit 8 holds the bit shifted out
      CSCR_OP_RLF: r = {f, st[0]};
      CSCR_OP_RRF: r = {f[0], st[0], f[7:1]};
      default:
      begin
        r[b] = 1'b0;
        upd = 1'b0;
      end
    endcase
    // Written bits: flags only when the op leaves them alone, never bits 4 and 3
    if (d)
    begin
      s[7:5] = {r[7], 1'b0, r[5]};
      if (!upd)
        s[2:0] = r[2:0];
    end
    // Computed flags win over written data
    if (upd && o != CSCR_OP_RLF && o != CSCR_OP_RRF)
      s[2] = (r[7:0] == 8'h00);
    if (o == CSCR_OP_RLF || o == CSCR_OP_RRF)
      s[0] = r[8];
    if (o == CSCR_OP_ADD)
      s[1:0] = {h[4], r[8]};
    if (o == CSCR_OP_SUB)
      s[1:0] = {~h[4], ~r[8]};
    return s;
  endfunction : nxt

  task automatic chk_status;
    n_compared++;
    if (status !== st || page !== st[5])
    begin
      n_fail++;
      $display("[FAIL] %0t status %h page %b, expected %h", $time, status, page, st);
    end
  endtask : chk_status

  task automatic chk_option;
    n_compared++;
    if (option !== opt)
    begin
      n_fail++;
      $display("[FAIL] %0t config %h, expected %h", $time, option, opt);
    end
  endtask : chk_option

  task automatic chk_pins(input logic [5:0] t);
    logic [5:0] eo;
    logic [5:0] ep;
    logic [5:0] ew;
    eo = ~t & ~(opt[5] ? 6'h04 : 6'h00);
    ep = t & 6'h0B & {6{~opt[6]}};
    ew = t & 6'h0B & {6{~opt[7]}};
    n_compared++;
    if (out_en !== eo || pull_en !== ep || wake_en !== ew)
    begin
      n_fail++;
      $display("[FAIL] %0t pins %h %h %h, expected %h %h %h", $time, out_en, pull_en,
        wake_en, eo, ep, ew);
    end
  endtask : chk_pins

  // One instruction, status checked after its registering edge
  task automatic do_op(input cscr_alu_op_t o, input logic [7:0] a, input logic [7:0] f,
    input logic [2:0] b, input logic d);
    @(posedge clk);
    exec <= 1'b1;
    op <= o;
    acc <= a;
    file_v <= f;
    bsel <= b;
    dest <= d;
    addr <= d ? 5'h03 : 5'h07;
    @(posedge clk);
    exec <= 1'b0;
    st = nxt(o, a, f, b, d);
    #1;
    chk_status();
    chk_option();
  endtask : do_op

  // Watchdog clear and sleep pulses
  task automatic ev(input logic w, input logic s);
    @(posedge clk);
    wd_clear <= w;
    sleep_p <= s;
    @(posedge clk);
    wd_clear <= 1'b0;
    sleep_p <= 1'b0;
    // With neither event the flags keep their value
    if (w || s)
    begin
      st[4] = 1'b1;
      st[3] = ~s;
    end
    #1;
    chk_status();
  endtask : ev

  task automatic opt_ld(input logic [7:0] v);
    @(posedge clk);
    opt_load <= 1'b1;
    acc <= v;
    @(posedge clk);
    opt_load <= 1'b0;
    opt = v;
    #1;
    chk_option();
  endtask : opt_ld

  task automatic pins(input logic [5:0] t);
    @(posedge clk);
    pin_dir <= t;
    repeat (2) @(posedge clk);
    #1;
    chk_pins(t);
  endtask : pins

  task automatic rst(input cscr_rst_kind_t k);
    @(posedge clk);
    srst <= 1'b1;
    kind <= k;
    @(posedge clk);
    srst <= 1'b0;
    st[7:5] = (k == CSCR_RST_PIN_WAKE) ? 3'b100 : 3'b000;
    if (k == CSCR_RST_WATCHDOG)
      st[4] = 1'b0;
    if (k == CSCR_RST_POWER)
      st = 8'h18;
    opt = 8'hFF;
    #1;
    chk_status();
    chk_option();
  endtask : rst

  task automatic results;
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  // Main sequence: corners first, then random traffic, then each reset cause
  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    kind = CSCR_RST_POWER;
    {exec, dest, wd_clear, sleep_p, opt_load} = 5'h00;
    op = CSCR_OP_MOVE;
    {acc, file_v, addr, bsel} = 24'h000000;
    pin_dir = 6'h3F;
    n_fail = 0;
    n_compared = 0;
    ra = 8'($urandom(47));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    st = 8'h18;
    opt = 8'hFF;
    #1;
    chk_status();
    chk_option();
    do_op(CSCR_OP_ADD, 8'h08, 8'h08, 3'h0, 1'b0);
    do_op(CSCR_OP_ADD, 8'hFF, 8'h01, 3'h0, 1'b0);
    do_op(CSCR_OP_SUB, 8'h35, 8'h35, 3'h0, 1'b0);
    do_op(CSCR_OP_SUB, 8'h01, 8'h10, 3'h0, 1'b0);
    do_op(CSCR_OP_MOVE, 8'hFF, st, 3'h0, 1'b1);
    do_op(CSCR_OP_CLR, 8'h00, st, 3'h0, 1'b1);
    do_op(CSCR_OP_BSET, 8'h00, st, 3'h5, 1'b1);
    do_op(CSCR_OP_ADD, 8'hFF, st, 3'h0, 1'b1);
    ev(1'b1, 1'b0);
    ev(1'b1, 1'b1);
    opt_ld(8'h20);
    pins(6'h00);
    pins(6'h0B);
    repeat (80)
    begin
      ra = 8'($urandom);
      rd = 1'($urandom);
      case ($urandom_range(3))
        0: do_op(ops[$urandom_range(10)], ra, rd ? st : 8'($urandom), 3'($urandom), rd);
        1: ev(rd, ra[0]);
        2: opt_ld(ra);
        default: pins(ra[5:0]);
      endcase
    end
    do_op(CSCR_OP_MOVE, 8'hE7, st, 3'h0, 1'b1);
    rst(CSCR_RST_CLEAR);
    do_op(CSCR_OP_MOVE, 8'hA0, st, 3'h0, 1'b1);
    opt_ld(8'h00);
    rst(CSCR_RST_WATCHDOG);
    opt_ld(8'h5A);
    rst(CSCR_RST_PIN_WAKE);
    rst(CSCR_RST_POWER);
    results();
  end

  // Hang guard, far beyond the expected run length
  initial
  begin
    #20000;
    n_fail++;
    $display("[FAIL] %0t run did not finish in time", $time);
    results();
  end

endmodule : cscr_regs_tb_top
